// ===== pio_pkg.sv
// package: register indices, field layout and carriers of the general-purpose line port
package pio_pkg;
   // number of general-purpose lines and lower-group width
   localparam int PIO_LINES = 9;
   localparam int PIO_LOW = 8;
   // raw inputs to filter: nine pins, trip pin, overcurrent
   localparam int PIO_RAW = 11;
   localparam int PIO_TRIP_BIT = 9;
   localparam int PIO_OVC_BIT = 10;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_LOWER_DIR = 8'h04;
   localparam logic [7:0] IDX_LOWER_DATA = 8'h05;
   localparam logic [7:0] IDX_LOWER_IEN = 8'h06;
   localparam logic [7:0] IDX_LOWER_FLAG = 8'h07;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h17;
   localparam logic [7:0] IDX_SW_TRIP = 8'h30;
   localparam logic [7:0] IDX_UPPER_DIR = 8'h44;
   localparam logic [7:0] IDX_UPPER_DATA = 8'h45;
   localparam logic [7:0] IDX_UPPER_IEN = 8'h46;
   localparam logic [7:0] IDX_UPPER_FLAG = 8'h47;
   localparam logic [7:0] IDX_PIN_SELECT = 8'h49;
   // word index sits above the two byte-offset bits
   localparam int ADDR_LSB = 2;
   localparam int ADDR_W = 12;
   // field positions
   localparam int UPPER_DATA_BIT = 0;
   localparam int UPPER_MODE_BIT = 1;
   localparam int IRQ_SYNC_BIT = 0;
   localparam int IRQ_TRIP_BIT = 1;
   // reset values
   localparam logic [7:0] SELECT_RST = 8'hff;
   localparam logic [1:0] UPPER_DATA_RST = 2'h2;
   localparam logic [PIO_RAW-1:0] STABLE_RST = 11'h200;
   // apb request carrier
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
   } pio_apb_req_type;
   // pin carrier toward the pads
   typedef struct packed {
      logic [PIO_LINES-1:0] level;
      logic [PIO_LINES-1:0] oe_n;
      logic [PIO_LINES-1:0] pull_down;
   } pio_pad_out_type;
endpackage

// ===== pio_port.sv
// general-purpose line port with change-of-state flags and merged peripheral interrupt
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE1 - select bit set means general-purpose, else alternate
// RULE2 - select register resets to all ones
// RULE3 - upper data bit one selects line eight mode
// RULE4 - direction bits: zero input, one output
// RULE5 - direction registers reset to input
// RULE6 - data reads pins or drives written values
// RULE7 - source needs enable, general-purpose, input
// RULE8 - change detection on both edges
// RULE9 - change sets flag, shared port interrupt
// RULE10 - flag register read returns then clears
// RULE11 - interrupt enables reset cleared
// RULE12 - every line pulled low internally
// RULE13 - software selects serial pins, minimum 0xd8
// RULE14 - external serial clock needs select bit three
// RULE15 - receive line choice frees other pin
// RULE16 - all sources merge onto active-low core line
// RULE17 - sync interrupt on rising sync pulse
// RULE18 - trip: falling pin, overcurrent, software write
// RULE19 - core input should be level sensitive
// RULE20 - core line low until all acknowledged
// RULE21 - status read clears trip and sync flags
// RULE22 - inputs synchronised, change versus previous sample
// RULE23 - event during flag read stays set
module pio_port import pio_pkg::*; (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [ADDR_W-1:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic [PIO_LINES-1:0] pad_in, // pin levels from pads
   output logic [PIO_LINES-1:0] pad_out, // pin drive levels
   output logic [PIO_LINES-1:0] pad_oe_n, // low while driving
   output logic [PIO_LINES-1:0] pad_pull_down, // internal pull-down enable
   input wire logic [PIO_LINES-1:0] alt_out, // alternate function drive level
   input wire logic [PIO_LINES-1:0] alt_drive, // alternate function drives pin
   output logic [PIO_LINES-1:0] alt_in, // filtered pin level to alternates
   input wire logic pwm_sync_pulse, // pwm sync pulse, same clock
   input wire logic pwm_trip_input_n, // trip pin, active low
   input wire logic current_sense_input, // overcurrent comparator output
   output logic port_irq, // shared line-change interrupt
   output logic peripheral_core_interrupt_n // merged core interrupt, low active
);

   // whole block state
   typedef struct packed {
      logic [7:0] pin_function_select;
      logic [7:0] lower_lines_direction;
      logic upper_line_direction;
      logic [7:0] lower_lines_data;
      logic [1:0] upper_line_data_and_mode;
      logic [7:0] lower_lines_irq_enable;
      logic upper_line_irq_enable;
      logic [7:0] lower_lines_change_flags;
      logic upper_line_change_flag;
      logic [1:0] peripheral_irq_status;
      logic [PIO_RAW-1:0] sync_a; // first stage
      logic [PIO_RAW-1:0] sync_b; // second stage
      logic [PIO_RAW-1:0] sync_c; // third stage
      logic [PIO_RAW-1:0] stable; // accepted level
      logic sync_prev; // last sync pulse sample
      logic [31:0] rdata; // registered read data
   } pio_state_type;

   pio_state_type state; // current state
   pio_state_type next_state; // next state
   pio_apb_req_type req; // bundled apb request

   // combinational helpers
   logic [PIO_LINES-1:0] gp_mode; // line in general-purpose mode
   logic [PIO_LINES-1:0] dir_out; // line is output
   logic [PIO_LINES-1:0] out_val; // written data
   logic [PIO_LINES-1:0] ien; // interrupt enables
   logic [PIO_LINES-1:0] eligible; // line may raise interrupt
   logic [PIO_LINES-1:0] changed; // filtered level changed
   logic [PIO_LINES-1:0] events; // change events to flag
   logic [PIO_LINES-1:0] rd_level; // data seen by reads
   logic [PIO_RAW-1:0] settle; // stages two and three agree
   logic [PIO_RAW-1:0] raw_in; // raw asynchronous inputs
   logic [PIO_RAW-1:0] next_stable; // accepted level next cycle
   logic [7:0] idx; // word index of request
   logic setup_rd; // read setup phase
   logic acc_wr; // write completes this edge
   logic acc_rd; // read completes this edge
   logic mapped; // address hits a register
   logic trip_fall; // trip pin falling edge
   logic ovc_rise; // overcurrent rising edge
   logic sync_rise; // sync pulse rising edge
   logic sw_trip; // software trip write
   pio_pad_out_type pads; // pad drive bundle

   // request bundle and decode
   always_comb begin
      req.sel = psel;
      req.enable = penable;
      req.write = pwrite;
      req.addr = paddr;
      req.wdata = pwdata;
      idx = req.addr[ADDR_LSB +: 8];
      setup_rd = req.sel && !req.enable && !req.write;
      acc_wr = req.sel && req.enable && req.write;
      acc_rd = req.sel && req.enable && !req.write;
      unique case (idx)
         IDX_LOWER_DIR, IDX_LOWER_DATA, IDX_LOWER_IEN, IDX_LOWER_FLAG, IDX_IRQ_STATUS,
         IDX_SW_TRIP, IDX_UPPER_DIR, IDX_UPPER_DATA, IDX_UPPER_IEN, IDX_UPPER_FLAG,
         IDX_PIN_SELECT: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // per-line configuration view
   always_comb begin
      gp_mode = {state.upper_line_data_and_mode[UPPER_MODE_BIT], // RULE3
                 state.pin_function_select}; // RULE1
      dir_out = {state.upper_line_direction, state.lower_lines_direction}; // RULE4
      out_val = {state.upper_line_data_and_mode[UPPER_DATA_BIT], state.lower_lines_data};
      ien = {state.upper_line_irq_enable, state.lower_lines_irq_enable};
      eligible = ien & gp_mode & ~dir_out; // RULE7
   end

   // input filter: a level counts once stages two and three agree
   always_comb begin
      raw_in = {current_sense_input, pwm_trip_input_n, pad_in};
      settle = ~(state.sync_b ^ state.sync_c); // RULE22
      next_stable = (state.sync_c & settle) | (state.stable & ~settle);
      changed = next_stable[PIO_LINES-1:0] ^ state.stable[PIO_LINES-1:0]; // RULE22
      events = changed & eligible; // RULE8
      trip_fall = state.stable[PIO_TRIP_BIT] && !next_stable[PIO_TRIP_BIT];
      ovc_rise = !state.stable[PIO_OVC_BIT] && next_stable[PIO_OVC_BIT];
      sync_rise = pwm_sync_pulse && !state.sync_prev; // RULE17
      sw_trip = acc_wr && (idx == IDX_SW_TRIP);
   end

   // read view: inputs show pin level, outputs show written value
   always_comb begin
      rd_level = (dir_out & out_val) | (~dir_out & state.stable[PIO_LINES-1:0]); // RULE6
   end

   // next-state logic: registers, flags and read data
   always_comb begin
      next_state = state;
      next_state.sync_a = raw_in;
      next_state.sync_b = state.sync_a;
      next_state.sync_c = state.sync_b;
      next_state.stable = next_stable;
      next_state.sync_prev = pwm_sync_pulse;
      // register writes take effect at the access edge
      if (acc_wr) begin
         unique case (idx)
            IDX_PIN_SELECT: next_state.pin_function_select = req.wdata[7:0]; // RULE1
            IDX_LOWER_DIR: next_state.lower_lines_direction = req.wdata[7:0]; // RULE4
            IDX_UPPER_DIR: next_state.upper_line_direction = req.wdata[0]; // RULE4
            IDX_LOWER_DATA: next_state.lower_lines_data = req.wdata[7:0]; // RULE6
            IDX_UPPER_DATA: next_state.upper_line_data_and_mode = req.wdata[1:0]; // RULE3
            IDX_LOWER_IEN: next_state.lower_lines_irq_enable = req.wdata[7:0];
            IDX_UPPER_IEN: next_state.upper_line_irq_enable = req.wdata[0];
            default: ; // read-only, software trip or unmapped: no register written
         endcase
      end
      // read of a flag register clears it; a same-cycle event is kept
      if (acc_rd && idx == IDX_LOWER_FLAG) begin
         next_state.lower_lines_change_flags = 8'h00; // RULE10
      end
      if (acc_rd && idx == IDX_UPPER_FLAG) begin
         next_state.upper_line_change_flag = 1'b0; // RULE10
      end
      if (acc_rd && idx == IDX_IRQ_STATUS) begin
         next_state.peripheral_irq_status = 2'h0; // RULE21
      end
      // set after clear so set wins
      next_state.lower_lines_change_flags = next_state.lower_lines_change_flags
                                            | events[PIO_LOW-1:0]; // RULE9 RULE23
      next_state.upper_line_change_flag = next_state.upper_line_change_flag
                                          | events[PIO_LOW]; // RULE9 RULE23
      if (sync_rise) begin
         next_state.peripheral_irq_status[IRQ_SYNC_BIT] = 1'b1; // RULE17
      end
      if (trip_fall || ovc_rise || sw_trip) begin
         next_state.peripheral_irq_status[IRQ_TRIP_BIT] = 1'b1; // RULE18
      end
      // read data captured in setup, presented in access
      if (setup_rd) begin
         next_state.rdata = 32'h0;
         unique case (idx)
            IDX_PIN_SELECT: next_state.rdata[7:0] = state.pin_function_select;
            IDX_LOWER_DIR: next_state.rdata[7:0] = state.lower_lines_direction;
            IDX_UPPER_DIR: next_state.rdata[0] = state.upper_line_direction;
            IDX_LOWER_DATA: next_state.rdata[7:0] = rd_level[PIO_LOW-1:0]; // RULE6
            IDX_UPPER_DATA: begin
               next_state.rdata[UPPER_DATA_BIT] = rd_level[PIO_LOW]; // RULE6
               next_state.rdata[UPPER_MODE_BIT] =
                  state.upper_line_data_and_mode[UPPER_MODE_BIT];
            end
            IDX_LOWER_IEN: next_state.rdata[7:0] = state.lower_lines_irq_enable;
            IDX_UPPER_IEN: next_state.rdata[0] = state.upper_line_irq_enable;
            // flags returned as held at the access edge
            IDX_LOWER_FLAG: next_state.rdata[7:0] = next_state.lower_lines_change_flags;
            IDX_UPPER_FLAG: next_state.rdata[0] = next_state.upper_line_change_flag;
            IDX_IRQ_STATUS: next_state.rdata[1:0] = next_state.peripheral_irq_status;
            default: next_state.rdata = 32'h0; // unmapped or write-only
         endcase
      end
   end

   // flag bits raised between setup and access still join the read
   logic [31:0] rd_late; // flags held during the access cycle
   always_comb begin
      rd_late = 32'h0;
      if (acc_rd && idx == IDX_LOWER_FLAG) begin
         rd_late[7:0] = state.lower_lines_change_flags;
      end
      if (acc_rd && idx == IDX_UPPER_FLAG) begin
         rd_late[0] = state.upper_line_change_flag;
      end
      if (acc_rd && idx == IDX_IRQ_STATUS) begin
         rd_late[1:0] = state.peripheral_irq_status;
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '0;
         state.pin_function_select <= SELECT_RST; // RULE2
         state.lower_lines_direction <= 8'h00; // RULE5
         state.upper_line_direction <= 1'b0; // RULE5
         state.upper_line_data_and_mode <= UPPER_DATA_RST;
         state.lower_lines_irq_enable <= 8'h00; // RULE11
         state.upper_line_irq_enable <= 1'b0; // RULE11
         state.sync_a <= STABLE_RST;
         state.sync_b <= STABLE_RST;
         state.sync_c <= STABLE_RST;
         state.stable <= STABLE_RST;
      end else begin
         state <= next_state;
      end
   end

   // pad drive: general-purpose lines use data and direction
   always_comb begin
      pads.level = (gp_mode & out_val) | (~gp_mode & alt_out);
      pads.oe_n = (gp_mode & ~dir_out) | (~gp_mode & ~alt_drive); // RULE4
      pads.pull_down = {PIO_LINES{1'b1}}; // RULE12
   end

   // outputs
   always_comb begin
      pad_out = pads.level;
      pad_oe_n = pads.oe_n;
      pad_pull_down = pads.pull_down;
      alt_in = state.stable[PIO_LINES-1:0];
      port_irq = |{state.upper_line_change_flag, state.lower_lines_change_flags}; // RULE9
      peripheral_core_interrupt_n = !(port_irq || |state.peripheral_irq_status); // RULE16 RULE20
      prdata = state.rdata | rd_late;
      pready = 1'b1;
      pslverr = req.sel && req.enable && !mapped;
   end

endmodule // pio_port

`default_nettype wire

// ===== pio_port_monitor.sv
// checker: port-level timing relations of the line port
`timescale 1ns/1ps
`default_nettype none
module pio_port_monitor import pio_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [PIO_LINES-1:0] pad_in,
   input wire logic [PIO_LINES-1:0] pad_pull_down,
   input wire logic pwm_sync_pulse,
   input wire logic port_irq,
   input wire logic peripheral_core_interrupt_n
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc; // access phase
   logic [7:0] idx; // word index
   logic flag_rd; // read of a change-flag register
   logic clr_rd; // read of any clearing register
   logic mapped; // index names a register
   assign acc = psel & penable;
   assign idx = paddr[9:2];
   assign flag_rd = acc & !pwrite & (idx == IDX_LOWER_FLAG || idx == IDX_UPPER_FLAG);
   assign clr_rd = flag_rd | (acc & !pwrite & (idx == IDX_IRQ_STATUS));
   assign mapped = idx inside {IDX_LOWER_DIR, IDX_LOWER_DATA, IDX_LOWER_IEN, IDX_LOWER_FLAG,
      IDX_IRQ_STATUS, IDX_SW_TRIP, IDX_UPPER_DIR, IDX_UPPER_DATA, IDX_UPPER_IEN,
      IDX_UPPER_FLAG, IDX_PIN_SELECT};
   property p_pull; &pad_pull_down; endproperty
   a_pull: assert property (p_pull) else $error("pull-down missing");
   property p_merge; port_irq |-> !peripheral_core_interrupt_n; endproperty
   a_merge: assert property (p_merge) else $error("port irq not merged");
   property p_port_hold; port_irq && !flag_rd |=> port_irq; endproperty
   a_port_hold: assert property (p_port_hold) else $error("port irq dropped");
   property p_core_hold; !peripheral_core_interrupt_n && !clr_rd |=> !peripheral_core_interrupt_n;
   endproperty
   a_core_hold: assert property (p_core_hold) else $error("core irq dropped");
   property p_unmapped; acc && !mapped |-> pslverr && pready; endproperty
   a_unmapped: assert property (p_unmapped) else $error("no error on unmapped index");
   property p_sw_trip; acc && pwrite && idx == IDX_SW_TRIP |-> ##[1:2] !peripheral_core_interrupt_n;
   endproperty
   a_sw_trip: assert property (p_sw_trip) else $error("software trip lost");
   property p_sync; $rose(pwm_sync_pulse) |-> ##[0:2] !peripheral_core_interrupt_n; endproperty
   a_sync: assert property (p_sync) else $error("sync irq lost");
   property p_change; $rose(port_irq) |-> $past(pad_in, 2) != $past(pad_in, 6); endproperty
   a_change: assert property (p_change) else $error("flag without pin change");
   c_irq: cover property ($rose(port_irq));
   c_flag_rd: cover property (flag_rd && port_irq);
   c_trip: cover property (acc && pwrite && idx == IDX_SW_TRIP);
endmodule // pio_port_monitor
bind pio_port pio_port_monitor pio_port_monitor_inst (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pready, .pslverr, .pad_in, .pad_pull_down, .pwm_sync_pulse, .port_irq,
   .peripheral_core_interrupt_n);
`default_nettype wire

// ===== pio_pad_model.sv
// board model: resolves each pin from port drive, board drive and pull-down
`timescale 1ns/1ps
`default_nettype none
module pio_pad_model import pio_pkg::*; (
   input wire logic pclk,
   input wire logic [PIO_LINES-1:0] pad_out,
   input wire logic [PIO_LINES-1:0] pad_oe_n,
   input wire logic [PIO_LINES-1:0] pad_pull_down,
   input wire logic [PIO_LINES-1:0] ext_level,
   input wire logic [PIO_LINES-1:0] ext_drive,
   output logic [PIO_LINES-1:0] pad_in
);
   logic [PIO_LINES-1:0] churn = '0; // floating unpulled line keeps changing
   always @(posedge pclk) churn <= ~churn;
   // port drive wins, then board drive, then pull-down, else floating
   assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_drive & ext_level)
      | (pad_oe_n & ~ext_drive & ~pad_pull_down & churn);
endmodule // pio_pad_model
`default_nettype wire

// ===== tb_pio_port.sv
// testbench: registers, pin drive, change flags and merged interrupt of the line port
`timescale 1ns/1ps
`default_nettype none
module tb_pio_port import pio_pkg::*; ;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, err, port_irq, peripheral_core_interrupt_n;
   logic [PIO_LINES-1:0] pad_in, pad_out, pad_oe_n, pad_pull_down, alt_in;
   logic [PIO_LINES-1:0] alt_out = '0, alt_drive = '0, ext_level = '0, ext_drive = '0;
   logic pwm_sync_pulse = 1'b0, pwm_trip_input_n = 1'b1, current_sense_input = 1'b0;
   int bad_count = 0, n_checks = 0, cyc = 0;
   always #10 pclk = ~pclk;
   pio_port pio_port_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .pad_in, .pad_out, .pad_oe_n, .pad_pull_down, .alt_out, .alt_drive,
      .alt_in, .pwm_sync_pulse, .pwm_trip_input_n, .current_sense_input, .port_irq,
      .peripheral_core_interrupt_n);
   pio_pad_model pio_pad_model_inst (.pclk, .pad_out, .pad_oe_n, .pad_pull_down, .ext_level,
      .ext_drive, .pad_in);
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic hold(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // one apb transfer, then an idle cycle
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int t;
      logic ok;
      t = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // request held; answer taken at the rising edge that sees pready high
      do begin
         @(posedge pclk);
         rd = prdata;
         err = pslverr;
         ok = pready;
         t++;
      end while (ok !== 1'b1 && t < 50);
      if (ok !== 1'b1) bad_count++;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
      apb(1'b1, idx, wd);
   endtask
   task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      check(rd, exp);
   endtask
   task automatic t_reset();
      rchk(IDX_PIN_SELECT, 32'hff);
      rchk(IDX_LOWER_DIR, 32'h0);
      rchk(IDX_UPPER_DIR, 32'h0);
      rchk(IDX_LOWER_IEN, 32'h0);
      rchk(IDX_UPPER_IEN, 32'h0);
      rchk(IDX_UPPER_DATA, 32'h2);
      rchk(IDX_LOWER_DATA, 32'h0);
      check(32'(pad_oe_n), 32'h1ff);
      apb(1'b0, 8'h14, 32'h0); // reserved index
      check(32'(err), 32'h1);
      check(rd, 32'h0);
   endtask
   task automatic t_drive();
      wr(IDX_LOWER_DIR, 32'h0f);
      wr(IDX_LOWER_DATA, 32'h05);
      check(32'({pad_oe_n, pad_out}), 32'h3e005);
      rchk(IDX_LOWER_DATA, 32'h05);
      wr(IDX_UPPER_DIR, 32'h1);
      wr(IDX_UPPER_DATA, 32'h3);
      check(32'({pad_oe_n[8], pad_out[8]}), 32'h1);
      alt_drive <= 9'h101; // alternates drive lines zero and eight low
      wr(IDX_UPPER_DATA, 32'h1);
      wr(IDX_PIN_SELECT, 32'hfe);
      check(32'({pad_oe_n, pad_out}), 32'h1e004);
      wr(IDX_PIN_SELECT, 32'hff);
      wr(IDX_UPPER_DATA, 32'h2);
      wr(IDX_LOWER_DIR, 32'h0);
      wr(IDX_UPPER_DIR, 32'h0);
      alt_drive <= '0;
   endtask
   task automatic t_change();
      wr(IDX_LOWER_IEN, 32'hff);
      wr(IDX_UPPER_IEN, 32'h1);
      ext_drive <= 9'h1ff; // board drives every line
      ext_level <= 9'h004;
      hold(6);
      check(32'({port_irq, peripheral_core_interrupt_n}), 32'h2);
      rchk(IDX_LOWER_FLAG, 32'h4);
      rchk(IDX_LOWER_FLAG, 32'h0);
      check(32'(port_irq), 32'h0);
      ext_level <= 9'h100; // line two falls, line eight rises
      hold(6);
      rchk(IDX_LOWER_FLAG, 32'h4);
      check(32'({port_irq, peripheral_core_interrupt_n}), 32'h2);
      rchk(IDX_UPPER_FLAG, 32'h1);
      rchk(IDX_UPPER_DATA, 32'h3);
      rchk(IDX_LOWER_DATA, 32'h0);
      wr(IDX_LOWER_IEN, 32'hbf); // line six masked
      wr(IDX_LOWER_DIR, 32'h08); // line three driven by the port
      wr(IDX_PIN_SELECT, 32'hd8); // serial pins alternate
      ext_level <= 9'h1ff;
      hold(6);
      rchk(IDX_LOWER_FLAG, 32'h90);
      rchk(IDX_UPPER_FLAG, 32'h0);
      ext_level <= '0;
      wr(IDX_PIN_SELECT, 32'hff);
      wr(IDX_LOWER_DIR, 32'h0);
      hold(6);
      apb(1'b0, IDX_LOWER_FLAG, 32'h0);
      apb(1'b0, IDX_UPPER_FLAG, 32'h0);
      check(32'(peripheral_core_interrupt_n), 32'h1);
   endtask
   task automatic t_periph();
      pwm_sync_pulse <= 1'b1;
      ext_level <= 9'h010; // line four rises too
      hold(1);
      pwm_sync_pulse <= 1'b0;
      hold(6);
      rchk(IDX_IRQ_STATUS, 32'h1);
      check(32'({port_irq, peripheral_core_interrupt_n}), 32'h2);
      rchk(IDX_LOWER_FLAG, 32'h10);
      rchk(IDX_IRQ_STATUS, 32'h0);
      check(32'(peripheral_core_interrupt_n), 32'h1);
      for (int k = 0; k < 3; k++) begin
         if (k == 0) pwm_trip_input_n <= 1'b0;
         if (k == 1) current_sense_input <= 1'b1;
         if (k == 2) wr(IDX_SW_TRIP, 32'h1);
         hold(6);
         rchk(IDX_IRQ_STATUS, 32'h2);
         pwm_trip_input_n <= 1'b1;
         current_sense_input <= 1'b0;
         hold(6);
         rchk(IDX_IRQ_STATUS, 32'h0);
      end
   endtask
   // hang guard
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_drive();
      t_change();
      t_periph();
      tally_and_finish();
   end
endmodule // tb_pio_port
`default_nettype wire
